/* File: rtl/cbu_pkg.sv */
package cbu_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PROG_CTR_W = 12;
  localparam int OFFSET_W   = 7;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 5;
  localparam int CNT_W      = 16;
  localparam int COND_W     = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing in core clock cycles
  localparam int NOT_TAKEN_CYCLES = 1;
  localparam int TAKEN_CYCLES     = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL        = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 5'h04;
  localparam logic [ADDR_W-1:0] REG_LAST_TARGET = 5'h08;
  localparam logic [ADDR_W-1:0] REG_TAKEN_CNT   = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_SEQ_CNT     = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_TAKEN_BIT  = 1;
  localparam int STAT_COND_LSB   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic                  CTRL_ENABLE_RST = 1'h1;
  localparam logic [CNT_W-1:0]      CNT_RST         = 16'h0000;
  localparam logic [CNT_W-1:0]      CNT_ONE         = 16'h0001;
  localparam logic [PROG_CTR_W-1:0] PROG_CTR_RST    = 12'h000;
  localparam logic [PROG_CTR_W-1:0] PROG_CTR_ONE    = 12'h001;
  localparam logic [DATA_W-1:0]     DATA_ZERO       = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Branch conditions as issued by the decoder
  typedef enum logic [COND_W-1:0] {
    branch_on_zero_set,
    branch_on_zero_clear,
    branch_on_carry_set,
    branch_on_carry_clear,
    branch_same_or_higher,
    branch_lower_unsigned,
    branch_on_negative,
    branch_on_positive,
    branch_signed_ge,
    branch_signed_lt,
    branch_on_half_carry_set
  } cbu_cond_t;

  function automatic logic [PROG_CTR_W-1:0] cbu_sext(input logic [OFFSET_W-1:0] off);
    cbu_sext = {{(PROG_CTR_W-OFFSET_W){off[OFFSET_W-1]}}, off};
  endfunction

endpackage

/* File: rtl/cbu_cond_eval.sv */
`timescale 1ns/100ps
module cbu_cond_eval
  import cbu_pkg::*;
(
  input  cbu_cond_t  i_cond,
  input  wire logic  i_flag_zero,
  input  wire logic  i_flag_carry,
  input  wire logic  i_flag_negative,
  input  wire logic  i_flag_overflow,
  input  wire logic  i_flag_half_carry,
  output logic       o_take
);

  always_comb begin
    unique case (i_cond)
      branch_on_zero_set:       o_take = i_flag_zero;
      branch_on_zero_clear:     o_take = !i_flag_zero;
      branch_on_carry_set:      o_take = i_flag_carry;
      branch_lower_unsigned:    o_take = i_flag_carry;
      branch_on_carry_clear:    o_take = !i_flag_carry;
      branch_same_or_higher:    o_take = !i_flag_carry;
      branch_on_negative:       o_take = i_flag_negative;
      branch_on_positive:       o_take = !i_flag_negative;
      branch_signed_ge:         o_take = !(i_flag_negative ^ i_flag_overflow);
      branch_signed_lt:         o_take = i_flag_negative ^ i_flag_overflow;
      branch_on_half_carry_set: o_take = i_flag_half_carry;
      default:                  o_take = 1'b0;
    endcase
  end

endmodule

/* File: rtl/cbu_target_calc.sv */
`timescale 1ns/100ps
module cbu_target_calc
  import cbu_pkg::*;
(
  input  wire logic [PROG_CTR_W-1:0] i_prog_ctr,
  input  wire logic [OFFSET_W-1:0]   i_offset,
  output logic      [PROG_CTR_W-1:0] o_target,
  output logic      [PROG_CTR_W-1:0] o_sequential
);

  // Offset counts words and wraps modulo the counter width
  assign o_target     = i_prog_ctr + cbu_sext(i_offset) + PROG_CTR_ONE;
  assign o_sequential = i_prog_ctr + PROG_CTR_ONE;

endmodule

/* File: rtl/cbu_branch_unit.sv */
`timescale 1ns/100ps
module cbu_branch_unit
  import cbu_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_br_valid,
  input  cbu_cond_t                  i_br_cond,
  input  wire logic [OFFSET_W-1:0]   i_br_offset,
  input  wire logic [PROG_CTR_W-1:0] i_program_counter,
  input  wire logic                  i_flag_zero,
  input  wire logic                  i_flag_carry,
  input  wire logic                  i_flag_negative,
  input  wire logic                  i_flag_overflow,
  input  wire logic                  i_flag_half_carry,
  output logic                       o_br_ready,
  output logic                       o_br_done,
  output logic                       o_br_taken,
  output logic      [PROG_CTR_W-1:0] o_next_program_counter,
  output logic                       o_status_write,
  input  wire logic [ADDR_W-1:0]     i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [DATA_W-1:0]     i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [DATA_W-1:0]     o_avs_readdata,
  output logic                       o_avs_waitrequest
);

  typedef enum logic {cbu_st_idle, cbu_st_taken} cbu_state_t;

  cbu_state_t             state;
  logic                   accept;
  logic                   take;
  logic [PROG_CTR_W-1:0]  target;
  logic [PROG_CTR_W-1:0]  sequential;
  logic [PROG_CTR_W-1:0]  target_q;
  cbu_cond_t              last_cond;
  logic                   ctrl_enable;
  logic [CNT_W-1:0]       taken_cnt;
  logic [CNT_W-1:0]       seq_cnt;
  logic                   bus_ack;
  logic                   wr_fire;
  logic                   clear_wr;
  logic [DATA_W-1:0]      rd_mux;
  logic [PROG_CTR_W-1:0]  exp_target;

  ////////////////////////////////////////////////////////////////////////////////
  // Condition evaluation and target arithmetic

  cbu_cond_eval u_cond_eval (
    .i_cond            (i_br_cond),
    .i_flag_zero       (i_flag_zero),
    .i_flag_carry      (i_flag_carry),
    .i_flag_negative   (i_flag_negative),
    .i_flag_overflow   (i_flag_overflow),
    .i_flag_half_carry (i_flag_half_carry),
    .o_take            (take)
  );

  cbu_target_calc u_target_calc (
    .i_prog_ctr   (i_program_counter),
    .i_offset     (i_br_offset),
    .o_target     (target),
    .o_sequential (sequential)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Issue handshake

  // A new branch is only taken in while the previous one has finished
  assign o_br_ready = ctrl_enable && (state == cbu_st_idle);
  assign accept     = i_br_valid && o_br_ready;

  // Branches only read the flags; the status write strobe never rises
  assign o_status_write = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: one cycle when falling through, two when jumping

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state <= cbu_st_idle;
    end else begin
      unique case (state)
        cbu_st_idle: begin
          if (accept && take) begin
            state <= cbu_st_taken;
          end
        end
        cbu_st_taken: begin
          state <= cbu_st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      target_q  <= PROG_CTR_RST;
      last_cond <= branch_on_zero_set;
    end else if (accept) begin
      target_q  <= target;
      last_cond <= i_br_cond;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_br_done              <= 1'b0;
      o_br_taken             <= 1'b0;
      o_next_program_counter <= PROG_CTR_RST;
    end else begin
      o_br_done <= 1'b0;
      if (state == cbu_st_taken) begin
        o_br_done              <= 1'b1;
        o_br_taken             <= 1'b1;
        o_next_program_counter <= target_q;
      end else if (accept && !take) begin
        o_br_done              <= 1'b1;
        o_br_taken             <= 1'b0;
        o_next_program_counter <= sequential;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Branch statistics; a count event in the clearing cycle is kept

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      taken_cnt <= CNT_RST;
    end else if (clear_wr) begin
      taken_cnt <= (state == cbu_st_taken) ? CNT_ONE : CNT_RST;
    end else if (state == cbu_st_taken) begin
      taken_cnt <= taken_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      seq_cnt <= CNT_RST;
    end else if (clear_wr) begin
      seq_cnt <= (accept && !take) ? CNT_ONE : CNT_RST;
    end else if (accept && !take) begin
      seq_cnt <= seq_cnt + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: every access waits exactly one cycle

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;
  assign wr_fire           = i_avs_write && bus_ack;
  assign clear_wr          = wr_fire && (i_avs_address == REG_CTRL) && i_avs_byteenable[0]
                             && i_avs_writedata[CTRL_CLEAR_BIT];

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_enable <= CTRL_ENABLE_RST;
    end else if (wr_fire && (i_avs_address == REG_CTRL) && i_avs_byteenable[0]) begin
      ctrl_enable <= i_avs_writedata[CTRL_ENABLE_BIT];
    end
  end

  always_comb begin
    rd_mux = DATA_ZERO;
    unique case (i_avs_address)
      REG_CTRL: begin
        rd_mux[CTRL_ENABLE_BIT] = ctrl_enable;
      end
      REG_STATUS: begin
        rd_mux[STAT_BUSY_BIT]                        = (state == cbu_st_taken);
        rd_mux[STAT_TAKEN_BIT]                       = o_br_taken;
        rd_mux[STAT_COND_LSB +: COND_W]              = last_cond;
      end
      REG_LAST_TARGET: begin
        rd_mux[PROG_CTR_W-1:0] = o_next_program_counter;
      end
      REG_TAKEN_CNT: begin
        rd_mux[CNT_W-1:0] = taken_cnt;
      end
      REG_SEQ_CNT: begin
        rd_mux[CNT_W-1:0] = seq_cnt;
      end
      default: begin
        rd_mux = DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_avs_readdata <= DATA_ZERO;
    end else if (i_avs_read && !bus_ack) begin
      o_avs_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  assign exp_target = i_program_counter + PROG_CTR_ONE
                      + {{(PROG_CTR_W-OFFSET_W){i_br_offset[OFFSET_W-1]}}, i_br_offset};

  property p_zero_set_jumps;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_zero_set && i_flag_zero)
      |=> !o_br_done ##1 (o_br_done && o_br_taken);
  endproperty
  a_zero_set_jumps: assert property (p_zero_set_jumps)
    else $error("zero-set branch did not jump after two cycles");

  property p_zero_clear_falls;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_zero_clear)
      |=> (o_br_done == $past(i_flag_zero));
  endproperty
  a_zero_clear_falls: assert property (p_zero_clear_falls)
    else $error("zero-clear branch decision wrong");

  property p_carry_set;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && (i_br_cond == branch_on_carry_set || i_br_cond == branch_lower_unsigned))
      |=> (o_br_done == !$past(i_flag_carry));
  endproperty
  a_carry_set: assert property (p_carry_set)
    else $error("carry-set branch decision wrong");

  property p_carry_clear;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && (i_br_cond == branch_on_carry_clear || i_br_cond == branch_same_or_higher))
      |=> ((state == cbu_st_taken) == !$past(i_flag_carry));
  endproperty
  a_carry_clear: assert property (p_carry_clear)
    else $error("carry-clear branch decision wrong");

  property p_negative_falls;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_negative && !i_flag_negative)
      |=> o_br_done && !o_br_taken;
  endproperty
  a_negative_falls: assert property (p_negative_falls)
    else $error("negative branch jumped with negative flag clear");

  property p_positive_jumps;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_positive && !i_flag_negative)
      |=> !o_br_ready ##1 (o_br_done && o_br_taken);
  endproperty
  a_positive_jumps: assert property (p_positive_jumps)
    else $error("positive branch did not jump with negative flag clear");

  property p_signed_ge;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_signed_ge)
      |-> ##2 ((o_br_done && o_br_taken) == !($past(i_flag_negative, 2)
                                              ^ $past(i_flag_overflow, 2)));
  endproperty
  a_signed_ge: assert property (p_signed_ge)
    else $error("signed greater-or-equal decision wrong");

  property p_signed_lt;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_signed_lt && (i_flag_negative ^ i_flag_overflow))
      |=> !o_br_done ##1 (o_br_done && o_br_taken);
  endproperty
  a_signed_lt: assert property (p_signed_lt)
    else $error("signed less-than branch did not jump");

  property p_half_carry;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_half_carry_set)
      |=> (o_br_done != $past(i_flag_half_carry));
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half-carry branch decision wrong");

  property p_fall_through_one_cycle;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && !take)
      |=> o_br_done && !o_br_taken && !o_status_write
          && (o_next_program_counter == $past(i_program_counter) + PROG_CTR_ONE);
  endproperty
  a_fall_through_one_cycle: assert property (p_fall_through_one_cycle)
    else $error("fall-through did not finish in one cycle");

  property p_taken_target;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && take)
      |-> ##2 (o_br_done && (o_next_program_counter == $past(exp_target, 2)));
  endproperty
  a_taken_target: assert property (p_taken_target)
    else $error("jump target is not counter plus signed offset plus one");

  property p_carry_clear_jumps;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && (i_br_cond == branch_on_carry_clear || i_br_cond == branch_same_or_higher)
     && !i_flag_carry)
      |=> !o_br_done ##1 (o_br_done && o_br_taken);
  endproperty
  a_carry_clear_jumps: assert property (p_carry_clear_jumps)
    else $error("carry-clear branch did not jump with carry clear");

  property p_negative_jumps;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_negative && i_flag_negative)
      |=> !o_br_ready ##1 (o_br_done && o_br_taken);
  endproperty
  a_negative_jumps: assert property (p_negative_jumps)
    else $error("negative branch did not jump with negative flag set");

  property p_positive_falls;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_on_positive && i_flag_negative)
      |=> o_br_done && !o_br_taken;
  endproperty
  a_positive_falls: assert property (p_positive_falls)
    else $error("positive branch jumped with negative flag set");

  property p_signed_ge_falls;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (accept && i_br_cond == branch_signed_ge && (i_flag_negative ^ i_flag_overflow))
      |=> o_br_done && !o_br_taken;
  endproperty
  a_signed_ge_falls: assert property (p_signed_ge_falls)
    else $error("signed greater-or-equal jumped with negative xor overflow set");

endmodule

/* File: verification/cbu_branch_unit_bench.sv */
`timescale 1ns/100ps
module cbu_branch_unit_bench
  import cbu_pkg::*;
;
  logic                  i_core_clk;
  logic                  i_reset_n;
  logic                  br_valid;
  cbu_cond_t             br_cond;
  logic [OFFSET_W-1:0]   br_offset;
  logic [PROG_CTR_W-1:0] prog_ctr;
  logic [4:0]            flags;
  logic [ADDR_W-1:0]     avs_addr;
  logic                  avs_read;
  logic                  avs_write;
  logic [DATA_W-1:0]     avs_wdata;
  logic [3:0]            avs_be;
  logic                  o_br_ready;
  logic                  o_br_done;
  logic                  o_br_taken;
  logic [PROG_CTR_W-1:0] o_next_program_counter;
  logic                  o_status_write;
  logic [DATA_W-1:0]     o_avs_readdata;
  logic                  o_avs_waitrequest;
  int                    err_count;
  int                    n_checks;
  int                    taken_cnt;
  int                    seq_cnt;

  cbu_branch_unit u_cbu_branch_unit (
    .i_core_clk             (i_core_clk),
    .i_reset_n              (i_reset_n),
    .i_br_valid             (br_valid),
    .i_br_cond              (br_cond),
    .i_br_offset            (br_offset),
    .i_program_counter      (prog_ctr),
    .i_flag_zero            (flags[0]),
    .i_flag_carry           (flags[1]),
    .i_flag_negative        (flags[2]),
    .i_flag_overflow        (flags[3]),
    .i_flag_half_carry      (flags[4]),
    .o_br_ready             (o_br_ready),
    .o_br_done              (o_br_done),
    .o_br_taken             (o_br_taken),
    .o_next_program_counter (o_next_program_counter),
    .o_status_write         (o_status_write),
    .i_avs_address          (avs_addr),
    .i_avs_read             (avs_read),
    .i_avs_write            (avs_write),
    .i_avs_writedata        (avs_wdata),
    .i_avs_byteenable       (avs_be),
    .o_avs_readdata         (o_avs_readdata),
    .o_avs_waitrequest      (o_avs_waitrequest)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pc(input logic [PROG_CTR_W-1:0] got, input logic [PROG_CTR_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Condition table: f = {h, v, n, c, z}
  function automatic logic exp_take(input int c, input logic [4:0] f);
    case (c)
      0:       exp_take = f[0];
      1:       exp_take = !f[0];
      2, 5:    exp_take = f[1];
      3, 4:    exp_take = !f[1];
      6:       exp_take = f[2];
      7:       exp_take = !f[2];
      8:       exp_take = !(f[2] ^ f[3]);
      9:       exp_take = f[2] ^ f[3];
      10:      exp_take = f[4];
      default: exp_take = 1'b0;
    endcase
  endfunction

  task automatic do_branch(input int c, input logic [4:0] f, input logic [OFFSET_W-1:0] off,
                           input logic [PROG_CTR_W-1:0] pc);
    logic                  et;
    logic [PROG_CTR_W-1:0] epc;
    int                    n;
    et  = exp_take(c, f);
    epc = et ? pc + {{(PROG_CTR_W-OFFSET_W){off[OFFSET_W-1]}}, off} + 12'h001 : pc + 12'h001;
    if (et) taken_cnt++;
    else seq_cnt++;
    @(posedge i_core_clk);
    br_valid  <= 1'b1;
    br_cond   <= cbu_cond_t'(c[COND_W-1:0]);
    br_offset <= off;
    prog_ctr  <= pc;
    flags     <= f;
    @(negedge i_core_clk);
    chk_bit(o_br_ready, 1'b1);
    // The request stands until the edge at which ready is sampled high
    do begin
      @(posedge i_core_clk);
    end while (o_br_ready !== 1'b1);
    br_valid <= 1'b0;
    flags    <= ~f;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
      if (n == 1 && et) chk_bit(o_br_ready, 1'b0);
    end while (o_br_done !== 1'b1 && n < 4);
    chk_word(n, et ? TAKEN_CYCLES : NOT_TAKEN_CYCLES);
    chk_bit(o_br_taken, et);
    chk_pc(o_next_program_counter, epc);
    chk_bit(o_status_write, 1'b0);
  endtask

  task automatic avs_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(posedge i_core_clk);
    avs_addr  <= a;
    avs_wdata <= wd;
    avs_read  <= !wr;
    avs_write <= wr;
    // Waitrequest low and read data are taken at one and the same rising edge
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    logic [DATA_W-1:0] rd;
    avs_xfer(1'b1, a, wd, rd);
  endtask

  task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] rd;
    avs_xfer(1'b0, a, DATA_ZERO, rd);
    chk_word(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    n_checks  = 0;
    taken_cnt = 0;
    seq_cnt   = 0;
    i_reset_n = 1'b0;
    br_valid  = 1'b0;
    br_cond   = branch_on_zero_set;
    br_offset = 7'h00;
    prog_ctr  = 12'h000;
    flags     = 5'h00;
    avs_addr  = 5'h00;
    avs_read  = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0000_0000;
    avs_be    = 4'hF;
    repeat (16) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    chk_pc(o_next_program_counter, PROG_CTR_RST);
    chk_bit(o_br_done, 1'b0);
    chk_bit(o_br_taken, 1'b0);
    chk_bit(o_br_ready, 1'b1);
    chk_bit(o_status_write, 1'b0);
    reg_chk(REG_CTRL, 32'h0000_0001);
    reg_chk(REG_STATUS, 32'h0000_0000);
    reg_chk(REG_LAST_TARGET, 32'h0000_0000);
    reg_chk(REG_TAKEN_CNT, 32'h0000_0000);
    reg_chk(REG_SEQ_CNT, 32'h0000_0000);
    // Unmapped place and masked lane
    reg_wr(5'h14, 32'hFFFF_FFFF);
    reg_chk(5'h14, 32'h0000_0000);
    avs_be <= 4'hE;
    reg_wr(REG_CTRL, 32'h0000_0000);
    avs_be <= 4'hF;
    reg_chk(REG_CTRL, 32'h0000_0001);
    // Every condition code against every flag pattern
    for (int c = 0; c < 12; c++) begin
      for (int f = 0; f < 32; f++) begin
        do_branch(c, 5'(f), 7'(f * 13 + c * 7), 12'(12'hFE0 + f * 3 + c * 40));
      end
    end
    // Wrap of the counter at both ends of the offset range
    do_branch(0, 5'h01, 7'h3F, 12'hFFF);
    do_branch(0, 5'h01, 7'h40, 12'h000);
    reg_chk(REG_LAST_TARGET, 32'h0000_0FC1);
    reg_chk(REG_STATUS, 32'h0000_0002);
    reg_chk(REG_TAKEN_CNT, 32'(taken_cnt));
    reg_chk(REG_SEQ_CNT, 32'(seq_cnt));
    do_branch(9, 5'h04, 7'h05, 12'h100);
    reg_chk(REG_STATUS, 32'h0000_0092);
    reg_wr(REG_CTRL, 32'h0000_0003);
    reg_chk(REG_TAKEN_CNT, 32'h0000_0000);
    reg_chk(REG_SEQ_CNT, 32'h0000_0000);
    reg_chk(REG_CTRL, 32'h0000_0001);
    // Disabled unit refuses a held request and takes it once enabled again
    reg_wr(REG_CTRL, 32'h0000_0000);
    @(posedge i_core_clk);
    br_valid  <= 1'b1;
    br_cond   <= branch_on_zero_set;
    br_offset <= 7'h02;
    prog_ctr  <= 12'h020;
    flags     <= 5'h01;
    repeat (3) begin
      @(negedge i_core_clk);
      chk_bit(o_br_ready, 1'b0);
      chk_bit(o_br_done, 1'b0);
    end
    reg_wr(REG_CTRL, 32'h0000_0001);
    do begin
      @(posedge i_core_clk);
    end while (o_br_ready !== 1'b1);
    br_valid <= 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk_bit(o_br_done, 1'b1);
    chk_bit(o_br_taken, 1'b1);
    chk_pc(o_next_program_counter, 12'h023);
    do_branch(1, 5'h00, 7'h7F, 12'h010);
    finish_test();
  end
endmodule
